/* File: hdl/itp_pkg.sv */
/*
 * Package for the isochronous transmit packing control block: register map,
 * field positions, reset values, packing modes and timing constants.
 * Assumes a 50 MHz system clock and 32-bit classic Wishbone register access.
 */
package itp_pkg;

	// ----------------------------------------------------------------
	// Register map
	// ----------------------------------------------------------------
	localparam logic [7:0]  ADDR_PACK_CONTROL  = 8'h20;
	localparam logic [7:0]  ADDR_HEADER_ONE    = 8'h24;
	localparam logic [7:0]  ADDR_HEADER_TWO    = 8'h28;
	localparam logic [7:0]  ADDR_STATUS        = 8'h2C;
	localparam logic [31:0] RST_PACK_CONTROL   = 32'h00000001;
	localparam logic [31:0] RST_HEADER_ONE     = 32'h00000000;
	localparam logic [31:0] RST_HEADER_TWO     = 32'h00000000;
	localparam logic [31:0] PACK_CONTROL_MASK  = 32'h7FFFFFFF;
	localparam logic [31:0] HEADER_ONE_MASK    = 32'h00FFFC00;
	localparam logic [31:0] HEADER_TWO_MASK    = 32'h3FFFFFFF;

	// ----------------------------------------------------------------
	// Field positions
	// ----------------------------------------------------------------
	localparam int POS_NET_AUDIO   = 30;
	localparam int POS_CLK_SEL     = 28;
	localparam int POS_TRDELAY     = 16;
	localparam int POS_MAX_BLOCKS  = 8;
	localparam int POS_EXT_STAMP   = 7;
	localparam int POS_FS_DELAY    = 5;
	localparam int POS_TX_EN       = 4;
	localparam int POS_PACK_MODE   = 2;
	localparam int POS_STAMP_EN    = 1;
	localparam int POS_SOFT_RST    = 0;
	localparam int POS_BLOCK_SIZE  = 16;
	localparam int POS_FRACTION    = 14;
	localparam int POS_PAD_COUNT   = 11;
	localparam int POS_PREFIX      = 10;

	// ----------------------------------------------------------------
	// Timing: 125 us bus cycle at 50 MHz, offset ticks, frame sync delay default
	// ----------------------------------------------------------------
	localparam int CLK_HZ          = 50_000_000;
	localparam int BUS_CYCLE_US    = 125;
	localparam int BUS_CYCLE_CLKS  = CLK_HZ / 1_000_000 * BUS_CYCLE_US;
	localparam int OFFSET_TICKS    = 3072;
	localparam logic [1:0] FS_DELAY_DEFAULT = 2'd3;

	// ----------------------------------------------------------------
	// Types
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		PM_VARIABLE,
		PM_FIXED,
		PM_MPEG2,
		PM_HEADER_ONLY
	} itp_pack_mode_t;

	typedef struct packed {
		logic        net_audio;
		logic [1:0]  clk_sel;
		logic [11:0] transport_delay;
		logic [7:0]  max_blocks;
		logic        ext_stamp;
		logic [1:0]  fs_delay;
		logic        tx_en;
		logic [1:0]  pack_mode;
		logic        stamp_en;
		logic        soft_rst;
	} itp_ctrl_t;

	typedef struct packed {
		logic [31:0] q1;
		logic [31:0] q2;
	} itp_header_t;

endpackage

/* File: hdl/itp_top.sv */
/*
 * Isochronous transmit packing control: three configuration registers on
 * classic Wishbone, SYT stamp generation from frame sync, CIP header build,
 * application packet acceptance and port clock generation.
 * Assumes a cycle timer from the link core and a packet engine that asks for
 * headers once per bus cycle and reports whether the payload is empty.
 */
// Our own choice: the Wishbone slave port.
`timescale 1ns/1ps

// Behaviour
// - Networked-audio mode holds pending stamp until a non-empty packet goes out.
// - Frame sync pulse makes stamp: delay plus cycle nibble with current offset.
// - Networked-audio mode adds two bus cycles to the programmed delay.
// - Clock select 00 makes port clock an input; others drive 24.576/12.288/6.144 MHz (here 25/12.5/6.25 MHz from 50 MHz, and only while tx_en is set).
// - Transport delay low nibble adds to offset top, rest to cycle count.
// - Block count field limits data blocks per bus packet payload.
// - External stamp quadlet comes first with sync and valid, replacing own stamp.
// - Delay code 01 is 2 cycles, 00 is 3, 10 is 4, 11 reserved.
// - Enable accepts packets and sends one per cycle; clearing finishes current one.
// - Packing mode picks variable, fixed, MPEG-2 or headers-only format.
// - Stamp insert enable generates SYT stamps into CIP header.
// - Transmitter reset flushes the FIFO and stops transmission at once.
// - Block size field in quadlets; zero means 256.
// - Fraction code 00/01/10/11 splits source packet into 1/2/4/8 blocks.
// - Pad quadlets appended before blocking; count below block size and 2^fraction.
// - Stamp-prefix flag puts a 25-bit cycle timer stamp before each packet.
// - Header quadlet two copied to CIP quadlet two with format field.
// - With stamping, low 16 bits are SYT if sync edge seen, else ones.
// - Without stamping, all 24 low bits sent as programmed.
module itp_top
(
	// Clock and reset
	input  wire logic                 clk_i,
	input  wire logic                 rst_i,
	// Wishbone slave
	input  wire logic                 cyc_i,
	input  wire logic                 stb_i,
	input  wire logic                 we_i,
	input  wire logic [7:0]           adr_i,
	input  wire logic [3:0]           sel_i,
	input  wire logic [31:0]          dat_i,
	output logic      [31:0]          dat_o,
	output logic                      ack_o,
	// Cycle timer from the link core
	input  wire logic [12:0]          cycle_count_i,
	input  wire logic [11:0]          cycle_offset_i,
	// Packet engine handshake
	input  wire logic                 hdr_req_i,
	input  wire logic                 payload_empty_i,
	input  wire logic                 packet_done_i,
	output itp_pkg::itp_header_t      header_o,
	output logic                      hdr_valid_o,
	output itp_pkg::itp_ctrl_t        ctrl_o,
	output logic                      tx_active_o,
	output logic                      fifo_flush_o,
	// Application port
	input  wire logic                 frame_sync_input_i,
	input  wire logic                 packet_sync_strobe_i,
	input  wire logic                 packet_valid_strobe_i,
	input  wire logic [7:0]           app_data_i,
	input  wire logic                 port_clock_pin_i,
	output logic                      port_clock_pin_o,
	output logic                      port_clock_pin_oe_n_o,
	output logic      [31:0]          ext_stamp_o,
	output logic                      ext_stamp_valid_o,
	output logic                      app_accept_o
);

	// ----------------------------------------------------------------
	// Registers and bus
	// ----------------------------------------------------------------
	logic [31:0] pack_control_ff;
	logic [31:0] header_one_ff;
	logic [31:0] header_two_ff;
	logic        ack_ff;
	logic [31:0] dat_ff;
	logic        bus_req;
	logic [31:0] wr_mask;
	itp_pkg::itp_ctrl_t ctrl;
	logic        tx_active_ff;
	logic        flush_ff;
	logic        pending_ff;

	assign bus_req = cyc_i && stb_i && !ack_ff;
	assign wr_mask = {{8{sel_i[3]}}, {8{sel_i[2]}}, {8{sel_i[1]}}, {8{sel_i[0]}}};
	assign ctrl = pack_control_ff[30:0];

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			pack_control_ff <= itp_pkg::RST_PACK_CONTROL;
			header_one_ff   <= itp_pkg::RST_HEADER_ONE;
			header_two_ff   <= itp_pkg::RST_HEADER_TWO;
		end
		else if (bus_req && we_i)
		begin
			case (adr_i)
				itp_pkg::ADDR_PACK_CONTROL:
					pack_control_ff <= ((pack_control_ff & ~wr_mask) | (dat_i & wr_mask))
						& itp_pkg::PACK_CONTROL_MASK;
				itp_pkg::ADDR_HEADER_ONE:
					header_one_ff <= ((header_one_ff & ~wr_mask) | (dat_i & wr_mask))
						& itp_pkg::HEADER_ONE_MASK;
				itp_pkg::ADDR_HEADER_TWO:
					header_two_ff <= ((header_two_ff & ~wr_mask) | (dat_i & wr_mask))
						& itp_pkg::HEADER_TWO_MASK;
				default:
					;
			endcase
		end
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			ack_ff <= 1'b0;
			dat_ff <= 32'h00000000;
		end
		else
		begin
			ack_ff <= bus_req;
			if (bus_req && !we_i)
			begin
				case (adr_i)
					itp_pkg::ADDR_PACK_CONTROL: dat_ff <= pack_control_ff;
					itp_pkg::ADDR_HEADER_ONE:   dat_ff <= header_one_ff;
					itp_pkg::ADDR_HEADER_TWO:   dat_ff <= header_two_ff;
					itp_pkg::ADDR_STATUS:       dat_ff <= {29'h0, pending_ff, tx_active_ff, flush_ff};
					default:                    dat_ff <= 32'h00000000;
				endcase
			end
		end
	end

	assign ack_o  = ack_ff;
	assign dat_o  = dat_ff;
	assign ctrl_o = ctrl;

	// ----------------------------------------------------------------
	// Input synchronisers
	// ----------------------------------------------------------------
	logic [1:0] fs_sync_ff;
	logic [1:0] psync_sync_ff;
	logic [1:0] pvalid_sync_ff;
	logic [7:0] data_meta_ff;
	logic [7:0] data_sync_ff;
	logic       fs_prev_ff;
	logic       fs_rise;

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			fs_sync_ff     <= 2'b00;
			psync_sync_ff  <= 2'b00;
			pvalid_sync_ff <= 2'b00;
			data_meta_ff   <= 8'h00;
			data_sync_ff   <= 8'h00;
			fs_prev_ff     <= 1'b0;
		end
		else
		begin
			fs_sync_ff     <= {fs_sync_ff[0], frame_sync_input_i};
			psync_sync_ff  <= {psync_sync_ff[0], packet_sync_strobe_i};
			pvalid_sync_ff <= {pvalid_sync_ff[0], packet_valid_strobe_i};
			data_meta_ff   <= app_data_i;
			data_sync_ff   <= data_meta_ff;
			fs_prev_ff     <= fs_sync_ff[1];
		end
	end

	assign fs_rise = fs_sync_ff[1] && !fs_prev_ff;

	// ----------------------------------------------------------------
	// Transmitter state: enable, soft reset, flush
	// ----------------------------------------------------------------
	always_ff @(posedge clk_i)
	begin
		if (rst_i || ctrl.soft_rst)
			tx_active_ff <= 1'b0;
		else if (ctrl.tx_en)
			tx_active_ff <= 1'b1;
		else if (packet_done_i)
			tx_active_ff <= 1'b0;
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			flush_ff <= 1'b1;
		else
			flush_ff <= ctrl.soft_rst;
	end

	assign tx_active_o  = tx_active_ff;
	assign fifo_flush_o = flush_ff;

	// ----------------------------------------------------------------
	// SYT stamp generation
	// ----------------------------------------------------------------
	logic [2:0]  fs_cycles;
	logic [15:0] syt_ff;
	logic        take_stamp;
	logic        hdr_valid_ff;
	itp_pkg::itp_header_t header_ff;

	always_comb
	begin
		case (ctrl.fs_delay)
			2'b01:   fs_cycles = 3'd2;
			2'b10:   fs_cycles = 3'd4;
			default: fs_cycles = {1'b0, itp_pkg::FS_DELAY_DEFAULT};
		endcase
		if (ctrl.net_audio)
			fs_cycles = fs_cycles + 3'd2;
	end

	assign take_stamp = hdr_req_i && tx_active_ff && !(ctrl.net_audio && payload_empty_i);

	always_ff @(posedge clk_i)
	begin
		if (rst_i || ctrl.soft_rst)
		begin
			syt_ff     <= 16'hFFFF;
			pending_ff <= 1'b0;
		end
		else if (fs_rise && ctrl.stamp_en)
		begin
			syt_ff     <= {4'(cycle_count_i[3:0] + {1'b0, fs_cycles}), cycle_offset_i};
			pending_ff <= 1'b1;
		end
		else if (take_stamp)
			pending_ff <= 1'b0;
	end

	// ----------------------------------------------------------------
	// Header build, one per bus cycle request
	// ----------------------------------------------------------------
	always_ff @(posedge clk_i)
	begin
		if (rst_i || ctrl.soft_rst)
		begin
			header_ff    <= '0;
			hdr_valid_ff <= 1'b0;
		end
		else
		begin
			hdr_valid_ff <= hdr_req_i && tx_active_ff;
			if (hdr_req_i && tx_active_ff)
			begin
				header_ff.q1 <= header_one_ff;
				header_ff.q2 <= {2'b10, header_two_ff[29:24], header_two_ff[23:16], header_two_ff[15:0]};
				if (ctrl.stamp_en)
					header_ff.q2[15:0] <= (pending_ff && take_stamp) ? syt_ff : 16'hFFFF;
				else
					header_ff.q2[23:0] <= header_two_ff[23:0];
			end
		end
	end

	assign header_o    = header_ff;
	assign hdr_valid_o = hdr_valid_ff;

	// ----------------------------------------------------------------
	// Application port: external stamp capture and prefix stamp
	// ----------------------------------------------------------------
	logic [1:0]  byte_idx_ff;
	logic        in_stamp_ff;
	logic [31:0] ext_ff;
	logic        ext_valid_ff;
	logic [24:0] prefix_stamp;
	logic [11:0] off_sum;
	logic [12:0] cnt_sum;

	// Transport delay: low nibble into offset top, remainder into count
	assign off_sum      = 12'(cycle_offset_i + {ctrl.transport_delay[3:0], 8'h00});
	assign cnt_sum      = 13'(cycle_count_i + {5'h00, ctrl.transport_delay[11:4]} + {12'h000, off_sum < cycle_offset_i});
	assign prefix_stamp = {cnt_sum, off_sum};

	always_ff @(posedge clk_i)
	begin
		if (rst_i || ctrl.soft_rst)
		begin
			byte_idx_ff  <= 2'd0;
			in_stamp_ff  <= 1'b0;
			ext_ff       <= 32'h00000000;
			ext_valid_ff <= 1'b0;
		end
		else
		begin
			ext_valid_ff <= 1'b0;
			if (pvalid_sync_ff[1] && ctrl.tx_en && ctrl.ext_stamp)
			begin
				if (psync_sync_ff[1])
				begin
					ext_ff      <= {data_sync_ff, 24'h000000};
					byte_idx_ff <= 2'd1;
					in_stamp_ff <= 1'b1;
				end
				else if (in_stamp_ff)
				begin
					ext_ff[31 - 8 * byte_idx_ff -: 8] <= data_sync_ff;
					byte_idx_ff <= 2'(byte_idx_ff + 2'd1);
					if (byte_idx_ff == 2'd3)
					begin
						in_stamp_ff  <= 1'b0;
						ext_valid_ff <= 1'b1;
					end
				end
			end
			else if (ctrl.tx_en && ctrl.pack_mode != itp_pkg::PM_HEADER_ONLY
					&& header_one_ff[itp_pkg::POS_PREFIX] && psync_sync_ff[1] && pvalid_sync_ff[1])
			begin
				ext_ff       <= {7'h00, prefix_stamp};
				ext_valid_ff <= 1'b1;
			end
		end
	end

	assign ext_stamp_o       = ext_ff;
	assign ext_stamp_valid_o = ext_valid_ff;
	assign app_accept_o      = ctrl.tx_en && !ctrl.soft_rst
		&& ctrl.pack_mode != itp_pkg::PM_HEADER_ONLY;

	// ----------------------------------------------------------------
	// Port clock generation: 50 MHz gives nearest integer divisors
	// ----------------------------------------------------------------
	logic [2:0] clk_div_ff;
	logic [2:0] clk_half;
	logic       pclk_ff;

	always_comb
	begin
		case (ctrl.clk_sel)
			2'b01:   clk_half = 3'd0;
			2'b10:   clk_half = 3'd1;
			default: clk_half = 3'd3;
		endcase
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i || ctrl.clk_sel == 2'b00)
		begin
			clk_div_ff <= 3'd0;
			pclk_ff    <= 1'b0;
		end
		else if (clk_div_ff >= clk_half)
		begin
			clk_div_ff <= 3'd0;
			pclk_ff    <= !pclk_ff;
		end
		else
			clk_div_ff <= 3'(clk_div_ff + 3'd1);
	end

	assign port_clock_pin_o      = pclk_ff;
	assign port_clock_pin_oe_n_o = !(ctrl.clk_sel != 2'b00 && ctrl.tx_en);

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	a_bus_ack_once: assert property (@(posedge clk_i) disable iff (rst_i)
		ack_o |=> !ack_o) else $error("ack held longer than one cycle");
	a_soft_rst_stop: assert property (@(posedge clk_i) disable iff (rst_i)
		ctrl.soft_rst |=> !tx_active_o && fifo_flush_o) else $error("soft reset did not stop transmitter");
	a_empty_holds: assert property (@(posedge clk_i) disable iff (rst_i)
		(ctrl.net_audio && ctrl.stamp_en && hdr_req_i && payload_empty_i && pending_ff && !fs_rise && !ctrl.soft_rst)
		|=> pending_ff) else $error("stamp released on empty packet");
	a_syt_default: assert property (@(posedge clk_i) disable iff (rst_i)
		(hdr_req_i && tx_active_o && ctrl.stamp_en && !pending_ff && !ctrl.soft_rst)
		|=> header_o.q2[15:0] == 16'hFFFF) else $error("no stamp but low bits not all ones");
	a_plain_copy: assert property (@(posedge clk_i) disable iff (rst_i)
		(hdr_req_i && tx_active_o && !ctrl.stamp_en && !ctrl.soft_rst)
		|=> header_o.q2[23:0] == $past(header_two_ff[23:0])) else $error("header two low bits altered");
	a_fmt_copy: assert property (@(posedge clk_i) disable iff (rst_i)
		(hdr_req_i && tx_active_o && !ctrl.soft_rst)
		|=> header_o.q2[29:24] == $past(header_two_ff[29:24])) else $error("format field wrong");
	a_stamp_delay: assert property (@(posedge clk_i) disable iff (rst_i)
		(fs_rise && ctrl.stamp_en && !ctrl.soft_rst && !ctrl.net_audio && ctrl.fs_delay == 2'b01)
		|=> syt_ff[15:12] == 4'($past(cycle_count_i[3:0]) + 4'd2)) else $error("stamp delay wrong");
	a_net_delay: assert property (@(posedge clk_i) disable iff (rst_i)
		(fs_rise && ctrl.stamp_en && !ctrl.soft_rst && ctrl.net_audio && ctrl.fs_delay == 2'b00)
		|=> syt_ff[15:12] == 4'($past(cycle_count_i[3:0]) + 4'd5)) else $error("networked delay wrong");
	a_clk_input: assert property (@(posedge clk_i) disable iff (rst_i)
		(ctrl.clk_sel == 2'b00) |-> port_clock_pin_oe_n_o) else $error("port clock driven in input mode");
	a_enable_done: assert property (@(posedge clk_i) disable iff (rst_i)
		(tx_active_o && !ctrl.tx_en && !packet_done_i && !ctrl.soft_rst) |=> tx_active_o)
		else $error("transmitter stopped before packet done");

endmodule

/* File: verification/itp_av_src.sv */
/*
 * Application data source model for the AV port: frame sync pulses and
 * external stamp quadlets, one byte per clock, first byte most significant.
 * Assumes the bench calls its tasks and shares the system clock.
 */
`timescale 1ns/1ps
module itp_av_src
(
	// Clock
	input  wire logic       clk_i,
	// Port pins
	output logic            frame_sync_o,
	output logic            pkt_sync_o,
	output logic            pkt_valid_o,
	output logic [7:0]      data_o
);
	initial
	begin
		frame_sync_o = 1'b0;
		pkt_sync_o   = 1'b0;
		pkt_valid_o  = 1'b0;
		data_o       = 8'h00;
	end

	// Held over several clocks so the synchroniser sees the edge
	task pulse_sync();
		@(posedge clk_i);
		frame_sync_o <= 1'b1;
		repeat (3) @(posedge clk_i);
		frame_sync_o <= 1'b0;
	endtask

	// Stamp quadlet first, sync and valid with its first byte
	task send_stamp(input logic [31:0] q);
		int k;
		for (k = 0; k < 4; k++)
		begin
			@(posedge clk_i);
			pkt_sync_o  <= (k == 0);
			pkt_valid_o <= 1'b1;
			data_o      <= q[31 - 8 * k -: 8];
		end
		@(posedge clk_i);
		pkt_sync_o  <= 1'b0;
		pkt_valid_o <= 1'b0;
		data_o      <= ~q[7:0];
	endtask
endmodule

/* File: verification/tb_top.sv */
/*
 * Self-checking bench for the isochronous transmit packing control block.
 * Assumes the design package and the AV source model are compiled first.
 */
`timescale 1ns/1ps
module tb_top;
	logic                 clk_i, rst_i, cyc_i, stb_i, we_i, ack_o;
	logic [7:0]           adr_i, app_data;
	logic [3:0]           sel_i;
	logic [31:0]          dat_i, dat_o, ext_stamp_o, hq1, hq2, ctl, q;
	logic                 hdr_req_i, payload_empty_i, packet_done_i, hdr_valid_o;
	logic                 tx_active_o, fifo_flush_o, ext_stamp_valid_o, app_accept_o;
	logic [12:0]          cycle_count_i;
	logic [11:0]          cycle_offset_i;
	logic                 fsync, psync, pvalid, pin_o, pin_oe_n;
	wire logic            pin_lvl;
	itp_pkg::itp_header_t header_o;
	itp_pkg::itp_ctrl_t   ctrl_o;
	logic [31:0]          rd_q[$], ext_q[$];
	logic [63:0]          hdr_q[$];
	logic [7:0]           ra[3];
	logic [31:0]          rm[3];
	int                   dl[3];
	int                   err_count, n_compared, seed, i;

	assign pin_lvl = pin_oe_n ? 1'b0 : pin_o;

	itp_top i_itp_top (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
		.adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
		.cycle_count_i(cycle_count_i), .cycle_offset_i(cycle_offset_i), .hdr_req_i(hdr_req_i),
		.payload_empty_i(payload_empty_i), .packet_done_i(packet_done_i), .header_o(header_o),
		.hdr_valid_o(hdr_valid_o), .ctrl_o(ctrl_o), .tx_active_o(tx_active_o), .fifo_flush_o(fifo_flush_o),
		.frame_sync_input_i(fsync), .packet_sync_strobe_i(psync), .packet_valid_strobe_i(pvalid),
		.app_data_i(app_data), .port_clock_pin_i(pin_lvl), .port_clock_pin_o(pin_o),
		.port_clock_pin_oe_n_o(pin_oe_n), .ext_stamp_o(ext_stamp_o),
		.ext_stamp_valid_o(ext_stamp_valid_o), .app_accept_o(app_accept_o));

	itp_av_src i_itp_av_src (.clk_i(clk_i), .frame_sync_o(fsync), .pkt_sync_o(psync),
		.pkt_valid_o(pvalid), .data_o(app_data));

	initial
	begin
		clk_i = 1'b0;
		forever #10 clk_i = ~clk_i;
	end

	// ----------------------------------------------------------------
	// Checking and closing
	// ----------------------------------------------------------------
	task automatic check(input logic [63:0] seen, input logic [63:0] exp);
		n_compared++;
		if (seen !== exp)
		begin
			err_count++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task results();
		if (err_count == 0 && n_compared > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	// Oldest note is taken whenever a result appears
	always @(posedge clk_i)
	begin
		if (ack_o && !we_i)
			check(dat_o, rd_q.size() ? rd_q.pop_front() : ~dat_o);
		if (hdr_valid_o)
			check(header_o, hdr_q.size() ? hdr_q.pop_front() : ~header_o);
		if (ext_stamp_valid_o)
			check(ext_stamp_o, ext_q.size() ? ext_q.pop_front() : ~ext_stamp_o);
	end

	initial
	begin
		#1_000_000;
		err_count++;
		results();
	end

	// ----------------------------------------------------------------
	// Drivers
	// ----------------------------------------------------------------
	task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge clk_i);
		cyc_i <= 1'b1;
		stb_i <= 1'b1;
		we_i  <= w;
		adr_i <= a;
		dat_i <= d;
		sel_i <= 4'hF;
		n = 0;
		do
		begin
			@(posedge clk_i);
			n++;
		end
		while (ack_o !== 1'b1 && n < 50);
		if (ack_o !== 1'b1)
		begin
			err_count++;
			results();
		end
		cyc_i <= 1'b0;
		stb_i <= 1'b0;
		we_i  <= 1'b0;
	endtask

	task rd(input logic [7:0] a, input logic [31:0] exp);
		rd_q.push_back(exp);
		wb(1'b0, a, 32'h00000000);
	endtask

	task wait_act(input logic v);
		int n;
		n = 0;
		while (tx_active_o !== v && n < 200)
		begin
			@(negedge clk_i);
			n++;
		end
		if (n == 200)
		begin
			err_count++;
			results();
		end
	endtask

	// Optional frame sync, then one header request
	task hdr(input logic fs, input logic empty, input logic [15:0] syt);
		if (fs)
		begin
			i_itp_av_src.pulse_sync();
			repeat (6) @(posedge clk_i);
		end
		hdr_q.push_back({hq1 & itp_pkg::HEADER_ONE_MASK, 2'b10, hq2[29:16], syt});
		@(posedge clk_i);
		hdr_req_i       <= 1'b1;
		payload_empty_i <= empty;
		@(posedge clk_i);
		hdr_req_i <= 1'b0;
		repeat (3) @(posedge clk_i);
	endtask

	function logic [15:0] stp(input int d);
		logic [3:0] nib;
		nib = cycle_count_i[3:0] + d[3:0];
		return {nib, cycle_offset_i};
	endfunction

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial
	begin
		seed = 55505;
		err_count = 0;
		n_compared = 0;
		ra = '{itp_pkg::ADDR_PACK_CONTROL, itp_pkg::ADDR_HEADER_ONE, itp_pkg::ADDR_HEADER_TWO};
		rm = '{itp_pkg::PACK_CONTROL_MASK, itp_pkg::HEADER_ONE_MASK, itp_pkg::HEADER_TWO_MASK};
		dl = '{3, 2, 4};
		{cyc_i, stb_i, we_i, hdr_req_i, payload_empty_i, packet_done_i} = 6'h00;
		rst_i = 1'b1;
		adr_i = 8'h00;
		sel_i = 4'hF;
		dat_i = 32'h00000000;
		cycle_count_i = 13'h0000;
		cycle_offset_i = 12'h000;
		repeat (20) @(posedge clk_i);
		rst_i <= 1'b0;
		@(negedge clk_i);
		check(fifo_flush_o, 1'b1);
		rd(ra[0], itp_pkg::RST_PACK_CONTROL);
		rd(ra[1], itp_pkg::RST_HEADER_ONE);
		rd(ra[2], itp_pkg::RST_HEADER_TWO);
		wb(1'b1, 8'h3C, $random(seed));
		rd(8'h3C, 32'h00000000);
		for (i = 0; i < 6; i++)
		begin
			ctl = $random(seed);
			wb(1'b1, ra[i % 3], ctl);
			rd(ra[i % 3], ctl & rm[i % 3]);
		end
		hq1 = ($random(seed) & 32'hFFFFC7FF) | 32'h00000400;
		hq2 = $random(seed);
		wb(1'b1, ra[1], hq1);
		wb(1'b1, ra[2], hq2);
		for (i = 0; i < 4; i++)
		begin
			ctl = ($random(seed) & 32'h000000EC) | 32'h01235A10 | (i << 28);
			wb(1'b1, ra[0], ctl);
			repeat (3) @(negedge clk_i);
			check(pin_oe_n, i == 0);
			check(ctrl_o, ctl[30:0]);
			check(app_accept_o, ctl[3:2] != 2'b11);
			if (i == 1)
			begin
				q[0] = pin_o;
				@(negedge clk_i);
				check(pin_o, !q[0]);
			end
		end
		check(fifo_flush_o, 1'b0);
		@(posedge clk_i);
		cycle_count_i <= 13'($random(seed));
		cycle_offset_i <= 12'($random(seed));
		ctl = 32'h01235A10;
		wb(1'b1, ra[0], ctl);
		check(app_accept_o, 1'b1);
		wait_act(1'b1);
		check(tx_active_o, 1'b1);
		hdr(1'b0, 1'b0, hq2[15:0]);
		wb(1'b1, ra[0], ctl | 32'h2);
		hdr(1'b0, 1'b0, 16'hFFFF);
		for (i = 0; i < 3; i++)
		begin
			wb(1'b1, ra[0], ctl | 32'h2 | (i << 5) | (i << 2));
			hdr(1'b1, 1'b0, stp(dl[i]));
		end
		wb(1'b1, ra[0], ctl | 32'h40000002);
		hdr(1'b1, 1'b1, 16'hFFFF);
		hdr(1'b0, 1'b0, stp(5));
		wb(1'b1, ra[0], ctl | 32'h00000080);
		q = $random(seed);
		ext_q.push_back(q);
		i_itp_av_src.send_stamp(q);
		repeat (10) @(posedge clk_i);
		wb(1'b1, ra[0], ctl);
		ext_q.push_back({7'h00, 25'({cycle_count_i, cycle_offset_i} + 25'h0012300)});
		i_itp_av_src.send_stamp(q);
		repeat (10) @(posedge clk_i);
		wb(1'b1, ra[0], ctl ^ 32'h00000010);
		repeat (4) @(negedge clk_i);
		check(tx_active_o, 1'b1);
		@(posedge clk_i);
		packet_done_i <= 1'b1;
		@(posedge clk_i);
		packet_done_i <= 1'b0;
		wait_act(1'b0);
		check(tx_active_o, 1'b0);
		wb(1'b1, ra[0], 32'h00000001);
		repeat (2) @(negedge clk_i);
		check(fifo_flush_o, 1'b1);
		check(app_accept_o, 1'b0);
		@(posedge clk_i);
		hdr_req_i <= 1'b1;
		@(posedge clk_i);
		hdr_req_i <= 1'b0;
		repeat (4) @(posedge clk_i);
		check(rd_q.size() + hdr_q.size() + ext_q.size(), 0);
		results();
	end
endmodule
